// ==== sync_burst_sram_port.sv ====
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Inputs sampled and read data driven from registers on rising edge.
// - Clock qualify high makes the edge ignored; every state holds.
// - All selects active, write enable high, load low starts a read.
// - Read data appears after the edge following the address edge.
// - Drivers on only while output enable low and a read is presented.
// - Any new command may follow a read on the very next cycle.
// - Deselect floats the data pins only after the next run edge.
// - Burst counter serves up to four beats from one address.
// - Burst order input low gives linear order, high gives interleaved.
// - Only the two lowest address bits move, wrapping modulo four.
// - Advance high steps the counter unless deselected, ignoring selects and write enable.
// - Read or write direction latched at load, kept for whole burst.
// - All selects active, write enable low, load low starts a write.
// - Edge after a write command floats data and parity pins.
// - Write data captured on second recognised edge after the command.
// - Only byte lanes with active-low select asserted are updated.
// - Linear adds beat index to start; interleaved exclusive-ors it.
// - Lane 0 is data 7:0 with parity 0; lane 1 is 15:8 with parity 1.
// - Comes out of reset deselected with data pins floating.
// - First clock after leaving deselect keeps the pins floating.
module sync_burst_sram_port #(
  parameter int ADDR_W = sram_port_pkg::ADDR_W,
  parameter int WBUF_DEPTH = sram_port_pkg::WBUF_DEPTH
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic clock_qualify_n_i,
  input wire logic chip_select_1_n_i,
  input wire logic chip_select_2_i,
  input wire logic chip_select_3_n_i,
  input wire logic advance_or_load_i,
  input wire logic write_enable_n_i,
  input wire logic [sram_port_pkg::LANES-1:0] byte_lane_select_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic burst_order_i,
  input wire logic output_enable_n_i,
  input wire logic [sram_port_pkg::DQ_W-1:0] data_i,
  output logic [sram_port_pkg::DQ_W-1:0] data_o,
  output logic [sram_port_pkg::PAR_W-1:0] parity_i_unused_o,
  input wire logic [sram_port_pkg::PAR_W-1:0] parity_io_i,
  output logic [sram_port_pkg::PAR_W-1:0] parity_io_o,
  output logic data_oe_n_o,
  output logic write_buffer_ready_o
);
  import sram_port_pkg::*;

  localparam int FIFO_W = ADDR_W + LANES + WORD_W;

  initial begin
    if (ADDR_W < BURST_W + 1 || WBUF_DEPTH < 2) begin
      $error("sync_burst_sram_port needs ADDR_W above 2 and a real buffer");
    end
  end

  // ==========================================================================
  // Command decode
  wire run = ce_i && !clock_qualify_n_i;
  wire sel_all = !chip_select_1_n_i && chip_select_2_i && !chip_select_3_n_i;
  wire cmd_load = !advance_or_load_i;
  wire cmd_read = cmd_load && sel_all && write_enable_n_i;
  wire cmd_write = cmd_load && sel_all && !write_enable_n_i;
  wire cmd_desel = cmd_load && !sel_all;
  wire cmd_adv = advance_or_load_i;

  // ==========================================================================
  // Pipeline state
  op_t op_a;
  op_t op_b;
  logic [ADDR_W-1:0] addr_a;
  logic [ADDR_W-1:0] addr_b;
  logic [LANES-1:0] lanes_n_a;
  logic [LANES-1:0] lanes_n_b;
  logic [BURST_W-1:0] start_lo;
  logic [BURST_W-1:0] beat;
  logic [WORD_W-1:0] dout;
  logic [WORD_W-1:0] mem [2**ADDR_W];

  wire [BURST_W-1:0] next_beat = BURST_W'(beat + BEAT_STEP);
  wire [BURST_W-1:0] burst_lo;
  wire bursting = cmd_adv && (op_a != OP_IDLE);
  wire [ADDR_W-1:0] next_addr_a = cmd_adv ?
    {addr_a[ADDR_W-1:BURST_W], burst_lo} : addr_i;
  wire [WORD_W-1:0] rd_word = mem[addr_a];
  wire [WORD_W-1:0] din = {parity_io_i, data_i};

  op_t next_op_a;
  assign next_op_a = cmd_adv ? op_a :
                     cmd_read ? OP_READ :
                     cmd_write ? OP_WRITE : OP_IDLE;

  burst_order u_order (
    .start_i(start_lo),
    .beat_i(next_beat),
    .interleave_i(burst_order_i),
    .addr_lo_o(burst_lo)
  );

  // ==========================================================================
  // Command and address stage. An advance while deselected stays deselected.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      op_a <= OP_IDLE;
      addr_a <= '0;
      lanes_n_a <= '1;
      start_lo <= BEAT_RESET;
      beat <= BEAT_RESET;
    end else if (run) begin
      op_a <= next_op_a;
      addr_a <= next_addr_a;
      lanes_n_a <= byte_lane_select_n_i;
      if (!cmd_adv) begin
        start_lo <= addr_i[BURST_W-1:0];
        beat <= BEAT_RESET;
      end else if (bursting) begin
        beat <= next_beat;
      end
    end
  end

  // ==========================================================================
  // Data stage and output register.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      op_b <= OP_IDLE;
      addr_b <= '0;
      lanes_n_b <= '1;
      dout <= WORD_RESET;
    end else if (run) begin
      op_b <= op_a;
      addr_b <= addr_a;
      lanes_n_b <= lanes_n_a;
      if (op_a == OP_READ) begin
        dout <= rd_word;
      end
    end
  end

  // Drivers are on only for a presented read; write data, deselect and the
  // first clock out of deselect all leave op_b other than a read.
  wire drive_on = (op_b == OP_READ) && !output_enable_n_i;
  assign data_oe_n_o = !drive_on;
  assign data_o = dout[DQ_W-1:0];
  assign parity_io_o = dout[WORD_W-1:DQ_W];
  assign parity_i_unused_o = '0;

  // ==========================================================================
  // Write buffer between the pins and the array. It drains only on edges
  // without a read, so back-to-back reads stall it. A read of a location
  // whose write still waits in the buffer returns the older contents; that
  // was traded for a single array port.
  wire wbuf_push = run && (op_b == OP_WRITE);
  wire wbuf_in_ready;
  wire wbuf_out_valid;
  wire wbuf_drain = run && (op_a != OP_READ);
  wire [FIFO_W-1:0] wbuf_out;

  word_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(WBUF_DEPTH)
  ) u_wbuf (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(wbuf_push),
    .in_ready_o(wbuf_in_ready),
    .in_data_i({addr_b, lanes_n_b, din}),
    .out_valid_o(wbuf_out_valid),
    .out_ready_i(wbuf_drain),
    .out_data_o(wbuf_out)
  );

  assign write_buffer_ready_o = wbuf_in_ready;

  wire [ADDR_W-1:0] wr_addr = wbuf_out[FIFO_W-1:LANES+WORD_W];
  wire [LANES-1:0] wr_lanes_n = wbuf_out[LANES+WORD_W-1:WORD_W];
  wire [WORD_W-1:0] wr_word = wbuf_out[WORD_W-1:0];
  wire wr_commit = wbuf_out_valid && wbuf_drain;
  wire [WORD_W-1:0] old_word = mem[wr_addr];
  wire [WORD_W-1:0] merged_word;

  // Lanes are merged into one word so the array has a single writer.
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign merged_word[g*LANE_DQ_W +: LANE_DQ_W] = !wr_lanes_n[g] ?
        wr_word[g*LANE_DQ_W +: LANE_DQ_W] :
        old_word[g*LANE_DQ_W +: LANE_DQ_W];
      assign merged_word[DQ_W+g] = !wr_lanes_n[g] ?
        wr_word[DQ_W+g] : old_word[DQ_W+g];
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (wr_commit) begin
      mem[wr_addr] <= merged_word;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_write_cmd;
    run && cmd_write;
  endsequence

  sequence s_two_more;
    run ##1 run;
  endsequence

  a_read_launch: assert property (
    run && cmd_read |=> op_a == OP_READ && addr_a == $past(addr_i))
    else $error("read command did not latch its address");

  a_read_data_out: assert property (
    run && op_a == OP_READ |=> dout == $past(rd_word) && op_b == OP_READ)
    else $error("read data not presented one edge after address");

  a_suspend_hold: assert property (
    !run |=> $stable(dout) && $stable(op_a) && $stable(op_b) && $stable(beat))
    else $error("state moved on a suspended edge");

  a_write_float: assert property (
    op_b == OP_WRITE |-> data_oe_n_o)
    else $error("data pins driven during a write");

  a_deselect_float: assert property (
    run && cmd_desel ##1 run |=> data_oe_n_o)
    else $error("pins still driven after pipelined deselect");

  a_write_capture: assert property (
    s_write_cmd ##1 s_two_more |-> wbuf_push && op_b == OP_WRITE)
    else $error("write data not taken on second edge");

  a_burst_keep_dir: assert property (
    run && bursting |=> op_a == $past(op_a) &&
      beat == BURST_W'($past(beat) + 1'b1))
    else $error("burst changed direction or failed to step");

  a_burst_high_bits: assert property (
    run && bursting |=>
      addr_a[ADDR_W-1:BURST_W] == $past(addr_a[ADDR_W-1:BURST_W]))
    else $error("burst disturbed upper address bits");

  a_idle_float: assert property (
    op_b == OP_IDLE |-> data_oe_n_o)
    else $error("pins driven while deselected");

endmodule : sync_burst_sram_port

`default_nettype wire

// ==== sram_port_pkg.sv ====
package sram_port_pkg;

  // ==========================================================================
  // Geometry of the memory word and address
  localparam int ADDR_W = 18;
  localparam int DQ_W = 16;
  localparam int PAR_W = 2;
  localparam int LANES = 2;
  localparam int LANE_DQ_W = 8;
  localparam int WORD_W = DQ_W + PAR_W;
  localparam int BURST_W = 2;

  // ==========================================================================
  // Write buffer sizing
  localparam int WBUF_DEPTH = 16;

  // ==========================================================================
  // Reset values and beat step
  localparam logic [BURST_W-1:0] BEAT_RESET = 2'h0;
  localparam logic [BURST_W-1:0] BEAT_STEP = 2'h1;
  localparam logic [WORD_W-1:0] WORD_RESET = 18'h00000;

  // ==========================================================================
  // Operation held in each pipeline stage
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00,
    OP_READ = 2'b01,
    OP_WRITE = 2'b10
  } op_t;

endpackage : sram_port_pkg

// ==== burst_order.sv ====
`timescale 1ns/1ps
`default_nettype none

module burst_order (
  input wire logic [sram_port_pkg::BURST_W-1:0] start_i,
  input wire logic [sram_port_pkg::BURST_W-1:0] beat_i,
  input wire logic interleave_i,
  output logic [sram_port_pkg::BURST_W-1:0] addr_lo_o
);
  import sram_port_pkg::*;

  // ==========================================================================
  // Beat address: exclusive-or for interleaved, sum modulo four for linear.
  wire [BURST_W-1:0] lin_addr = BURST_W'(start_i + beat_i);
  wire [BURST_W-1:0] ilv_addr = start_i ^ beat_i;

  assign addr_lo_o = interleave_i ? ilv_addr : lin_addr;

endmodule : burst_order

`default_nettype wire

// ==== word_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PTR_W = $clog2(DEPTH);

  // ==========================================================================
  // Pointers carry one extra bit so full and empty stay distinct.
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("word_fifo needs a power-of-two depth of at least two");
    end
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W:0] wr_ptr;
  logic [PTR_W:0] rd_ptr;

  wire empty = (wr_ptr == rd_ptr);
  wire full = (wr_ptr[PTR_W] != rd_ptr[PTR_W]) &&
              (wr_ptr[PTR_W-1:0] == rd_ptr[PTR_W-1:0]);
  wire push = in_valid_i && !full;
  wire pop = out_ready_i && !empty;

  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = store[rd_ptr[PTR_W-1:0]];

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      store[wr_ptr[PTR_W-1:0]] <= in_data_i;
    end
  end

  a_fifo_no_overrun: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    full && !pop |=> full)
    else $error("fifo lost its full state without a pop");

endmodule : word_fifo

`default_nettype wire

// ==== sram_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Controller model on the far side of the memory port
module sram_ctrl_model #(
  parameter int AW = 6
) (
  input wire logic clk_i,
  input wire logic oe_n_i,
  input wire logic [sram_port_pkg::WORD_W-1:0] mem_i,
  output logic qual_n_o,
  output logic ce_o,
  output logic cs1_n_o,
  output logic cs2_o,
  output logic cs3_n_o,
  output logic adv_o,
  output logic we_n_o,
  output logic [1:0] lanes_n_o,
  output logic [AW-1:0] addr_o,
  output logic [sram_port_pkg::WORD_W-1:0] bus_o
);
  import sram_port_pkg::*;
  logic [WORD_W-1:0] cmd_w, st0_d, st1_d, wd, last;
  logic st0_w, st1_w, drv, dir_w, is_w;

  initial begin
    {st0_w, st1_w, drv, dir_w, qual_n_o} = 5'h00;
    {cmd_w, st0_d, st1_d, wd, last} = '0;
    {ce_o, cs1_n_o, cs2_o, cs3_n_o, adv_o, we_n_o} = 6'h35;
    lanes_n_o = 2'h3;
    addr_o = '0;
  end

  // A released bus shows a changing pattern, never its value at the previous edge.
  assign bus_o = !oe_n_i ? mem_i : (drv ? wd : ~last);
  assign is_w = adv_o ? dir_w : (!we_n_o && !cs1_n_o);

  always @(posedge clk_i) begin
    if (!qual_n_o && ce_o) begin
      if (!adv_o) dir_w <= is_w;
      st0_w <= is_w;
      st0_d <= cmd_w;
      st1_w <= st0_w;
      st1_d <= st0_d;
    end
    last <= bus_o;
  end

  // Write data is put out half a cycle before the second run edge.
  always @(negedge clk_i) begin
    drv <= st1_w;
    wd <= st1_d;
  end

  // Kind 0 deselect, 1 read, 2 write, 3 advance with selects inactive.
  task automatic op(input int kind, input logic [AW-1:0] a,
                    input logic [1:0] ln, input logic [WORD_W-1:0] w);
    @(negedge clk_i);
    cs1_n_o = (kind == 0 || kind == 3);
    cs2_o = !cs1_n_o;
    cs3_n_o = cs1_n_o;
    adv_o = (kind == 3);
    we_n_o = (kind != 2);
    lanes_n_o = ln;
    addr_o = a;
    cmd_w = w;
  endtask : op

  task automatic susp(input logic q, input logic c);
    @(negedge clk_i);
    qual_n_o = q;
    ce_o = c;
  endtask : susp
endmodule : sram_ctrl_model

`default_nettype wire

// ==== sync_burst_sram_port_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Testbench top
module sync_burst_sram_port_tb;
  import sram_port_pkg::*;
  localparam int AW = 6;
  logic clk_i = 1'h0;
  logic arst_n_i = 1'h0;
  logic order = 1'h0;
  logic oe_n = 1'h0;
  logic qn, ce, c1n, c2, c3n, adv, wen, oen, rdy;
  logic [1:0] ln, par, pu;
  logic [AW-1:0] addr;
  logic [DQ_W-1:0] dq;
  logic [WORD_W-1:0] bus, rd;
  int mismatches = 0;
  int samples_checked = 0;

  assign rd = {par, dq};
  initial forever #50 clk_i = ~clk_i;

  sync_burst_sram_port #(.ADDR_W(AW)) dut_u (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce),
    .clock_qualify_n_i(qn), .chip_select_1_n_i(c1n),
    .chip_select_2_i(c2), .chip_select_3_n_i(c3n),
    .advance_or_load_i(adv), .write_enable_n_i(wen),
    .byte_lane_select_n_i(ln), .addr_i(addr), .burst_order_i(order),
    .output_enable_n_i(oe_n), .data_i(bus[DQ_W-1:0]), .data_o(dq),
    .parity_i_unused_o(pu), .parity_io_i(bus[WORD_W-1:DQ_W]),
    .parity_io_o(par), .data_oe_n_o(oen), .write_buffer_ready_o(rdy));

  sram_ctrl_model #(.AW(AW)) ctrl_u (
    .clk_i(clk_i), .oe_n_i(oen), .mem_i(rd), .qual_n_o(qn), .ce_o(ce),
    .cs1_n_o(c1n), .cs2_o(c2), .cs3_n_o(c3n), .adv_o(adv), .we_n_o(wen),
    .lanes_n_o(ln), .addr_o(addr), .bus_o(bus));

  // ========================================================================
  // Shared helpers
  function automatic logic [WORD_W-1:0] pat(input logic [5:0] a);
    return {a[1:0], 8'hC3 ^ {2'h0, a}, {2'h0, a}};
  endfunction : pat

  task automatic chk(input string what, input logic [WORD_W-1:0] exp,
                     input logic [WORD_W-1:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic idle(input int n);
    for (int i = 0; i < n; i++) ctrl_u.op(0, 6'h00, 2'h3, 18'h00000);
  endtask : idle

  task automatic stop_test();
    $display("mismatches %0d samples_checked %0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  // ========================================================================
  // Scenarios
  task automatic t_fill();
    ctrl_u.op(2, 6'h00, 2'h0, pat(6'h00));
    for (int i = 1; i < 8; i++) begin
      ctrl_u.op(i < 4 ? 3 : 2, 6'(i), 2'h0, pat(6'(i)));
    end
    chk("oe_n after write", 18'h00001, 18'(oen));
    idle(12);
  endtask : t_fill

  task automatic t_read(input logic mode, input logic [5:0] s);
    logic [5:0] a;
    order = mode;
    ctrl_u.op(1, s, 2'h3, 18'h00000);
    for (int i = 1; i < 6; i++) begin
      ctrl_u.op(i < 4 ? 3 : 0, 6'h00, 2'h3, 18'h00000);
      if (i == 1) chk("oe_n first clock", 18'h00001, 18'(oen));
      if (i >= 2) begin
        a = {s[5:2], mode ? s[1:0] ^ 2'(i - 2) : s[1:0] + 2'(i - 2)};
        chk("burst data", pat(a), rd);
      end
    end
    chk("oe_n before float", 18'h00000, 18'(oen));
    idle(1);
    chk("oe_n deselected", 18'h00001, 18'(oen));
  endtask : t_read

  task automatic t_lanes();
    ctrl_u.op(1, 6'h02, 2'h3, 18'h00000);
    ctrl_u.op(2, 6'h08, 2'h0, 18'h3FFFF);
    ctrl_u.op(2, 6'h08, 2'h2, 18'h00000);
    chk("read then write", pat(6'h02), rd);
    ctrl_u.op(2, 6'h08, 2'h3, 18'h00000);
    chk("oe_n write float", 18'h00001, 18'(oen));
    idle(12);
    ctrl_u.op(1, 6'h08, 2'h3, 18'h00000);
    idle(2);
    chk("lane merge", 18'h2FF00, rd);
  endtask : t_lanes

  task automatic t_suspend(input logic q, input logic c);
    ctrl_u.op(1, 6'h05, 2'h3, 18'h00000);
    ctrl_u.op(1, 6'h06, 2'h3, 18'h00000);
    ctrl_u.susp(q, c);
    for (int i = 0; i < 3; i++) begin
      @(negedge clk_i);
      chk("held data", pat(6'h05), rd);
    end
    oe_n = 1'h1;
    #1;
    chk("oe_n released", 18'h00001, 18'(oen));
    oe_n = 1'h0;
    ctrl_u.susp(1'h0, 1'h1);
    idle(1);
    chk("next data", pat(6'h06), rd);
    idle(2);
  endtask : t_suspend

  // ========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (3) @(negedge clk_i);
    arst_n_i = 1'h1;
    chk("oe_n reset", 18'h00001, 18'(oen));
    chk("ready reset", 18'h00001, 18'(rdy));
    chk("unused parity", 18'h00000, 18'(pu));
    t_fill();
    for (int m = 0; m < 2; m++) begin
      t_read(1'(m), 6'h01);
      t_read(1'(m), 6'h06);
    end
    t_lanes();
    t_suspend(1'h1, 1'h1);
    t_suspend(1'h0, 1'h0);
    stop_test();
  end

  initial begin
    repeat (1000) @(posedge clk_i);
    mismatches++;
    stop_test();
  end
endmodule : sync_burst_sram_port_tb

`default_nettype wire
